// ### rtl/meter_agc_pkg.sv
package meter_agc_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned AXI_ADDR_W = 12;
    localparam int unsigned AXI_DATA_W = 32;
    localparam int unsigned REG_W      = 16;
    localparam int unsigned IDX_W      = 6;
    localparam int unsigned BYTE_SHIFT = 2;

    // ----------------------------------------------------------------
    // register indices (word index; byte address is four times it)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_GAIN_LOOP_FILTER_CONFIG     = 6'h00;
    localparam logic [IDX_W-1:0] IDX_METER_TWO_LOW_WORD          = 6'h28;
    localparam logic [IDX_W-1:0] IDX_METER_TWO_MID_WORD          = 6'h29;
    localparam logic [IDX_W-1:0] IDX_METER_TWO_LOWER_HIGH_WORD   = 6'h2a;
    localparam logic [IDX_W-1:0] IDX_METER_TWO_TOP_WORD          = 6'h2b;
    localparam logic [IDX_W-1:0] IDX_METER_THREE_LOW_WORD        = 6'h2c;
    localparam logic [IDX_W-1:0] IDX_METER_THREE_MID_WORD        = 6'h2d;
    localparam logic [IDX_W-1:0] IDX_METER_THREE_LOWER_HIGH_WORD = 6'h2e;
    localparam logic [IDX_W-1:0] IDX_METER_THREE_TOP_WORD        = 6'h2f;

    // ----------------------------------------------------------------
    // meter result layout
    // ----------------------------------------------------------------
    localparam int unsigned METER_W       = 58;
    localparam int unsigned TOP_FIELD_W   = 10;
    localparam logic [METER_W-1:0] METER_RESET = 58'h000_0000_0000_0000;

    // ----------------------------------------------------------------
    // gain configuration word layout (channel i at base - i)
    // ----------------------------------------------------------------
    localparam int unsigned HIGHPASS_BASE      = 15;
    localparam int unsigned SIGNAL_DETECT_BASE = 11;
    localparam int unsigned BYPASS_BASE        = 7;
    localparam int unsigned CHANNELS_MAX       = 4;
    localparam logic [REG_W-1:0] CFG_RESET     = 16'h0000;
    localparam logic [REG_W-1:0] CFG_USED_MASK = 16'hfff0;

    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : meter_agc_pkg

// ### rtl/power_meter_readout_agc_cfg.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// How it works
// - third meter bits 15:0 at word 0x28
// - third meter bits 31:16 at word 0x29
// - third meter bits 47:32 at word 0x2a
// - third meter bits 57:48, upper six zero
// - fourth meter bits 15:0 at word 0x2c
// - fourth meter bits 31:16 at word 0x2d
// - fourth meter bits 47:32 at word 0x2e
// - fourth meter bits 57:48, upper six zero
// - high-pass active only while enable bit set
// - signal detect active only while enable set
// - bypass routes signal around gain block
module power_meter_readout_agc_cfg
    import meter_agc_pkg::*;
#(
    parameter int unsigned CHANNELS = 4,
    parameter int unsigned SAMPLE_W = 16
) (
    // clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // axi4-lite write address
    input  wire logic [AXI_ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    // axi4-lite write data
    input  wire logic [AXI_DATA_W-1:0]        s_axi_wdata,
    input  wire logic [AXI_DATA_W/8-1:0]      s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // axi4-lite read address
    input  wire logic [AXI_ADDR_W-1:0]        s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    // axi4-lite read data
    output logic [AXI_DATA_W-1:0]             s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // meter results from the measurement logic
    input  wire logic [METER_W-1:0]           third_meter_result,
    input  wire logic [METER_W-1:0]           fourth_meter_result,
    input  wire logic                         meter_update,
    // per-channel samples, channel i in slice i
    input  wire logic [CHANNELS*SAMPLE_W-1:0] raw_sample,
    input  wire logic [CHANNELS*SAMPLE_W-1:0] gain_adjusted_sample,
    output logic [CHANNELS*SAMPLE_W-1:0]      chan_sample,
    // per-channel block enables
    output logic [CHANNELS-1:0]               highpass_enable_bit,
    output logic [CHANNELS-1:0]               signal_detect_enable_bit,
    output logic [CHANNELS-1:0]               gain_bypass
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (CHANNELS < 1 || CHANNELS > CHANNELS_MAX) begin : g_bad_channels
        $error("CHANNELS must lie between 1 and 4");
    end
    if (SAMPLE_W < 1) begin : g_bad_width
        $error("SAMPLE_W must be at least 1");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                         awready;
        logic                         wready;
        logic                         aw_held;
        logic                         w_held;
        logic [IDX_W-1:0]             wr_idx;
        logic                         wr_aligned;
        logic [REG_W-1:0]             wr_data;
        logic [1:0]                   wr_strb;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         arready;
        logic                         rvalid;
        logic [AXI_DATA_W-1:0]        rdata;
        logic [1:0]                   rresp;
        logic [METER_W-1:0]           meter_two;
        logic [METER_W-1:0]           meter_three;
        logic [REG_W-1:0]             cfg;
        logic [CHANNELS*SAMPLE_W-1:0] chan;
    } state_t;

    state_t                      s_r;
    state_t                      s_nxt;
    logic [CHANNELS*SAMPLE_W-1:0] routed_sample;
    logic [CHANNELS-1:0]          hp_field;
    logic [CHANNELS-1:0]          sd_field;
    logic [CHANNELS-1:0]          byp_field;

    // ----------------------------------------------------------------
    // per-channel field pick and sample routing
    // ----------------------------------------------------------------
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
        assign hp_field[i]  = s_r.cfg[HIGHPASS_BASE-i];
        assign sd_field[i]  = s_r.cfg[SIGNAL_DETECT_BASE-i];
        assign byp_field[i] = s_r.cfg[BYPASS_BASE-i];
        // bypass takes the raw stream so the loop's gain never reaches it
        assign routed_sample[i*SAMPLE_W +: SAMPLE_W] = byp_field[i]
            ? raw_sample[i*SAMPLE_W +: SAMPLE_W]
            : gain_adjusted_sample[i*SAMPLE_W +: SAMPLE_W];
    end

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    function automatic logic [REG_W:0] read_word(input logic [IDX_W-1:0] idx,
                                                 input state_t s);
        logic [REG_W:0] r;
        r = {1'b1, 16'h0000};
        case (idx)
            IDX_GAIN_LOOP_FILTER_CONFIG:     r[REG_W-1:0] = s.cfg & CFG_USED_MASK;
            IDX_METER_TWO_LOW_WORD:          r[REG_W-1:0] = s.meter_two[15:0];
            IDX_METER_TWO_MID_WORD:          r[REG_W-1:0] = s.meter_two[31:16];
            IDX_METER_TWO_LOWER_HIGH_WORD:   r[REG_W-1:0] = s.meter_two[47:32];
            IDX_METER_TWO_TOP_WORD:
                r[REG_W-1:0] = {6'h00, s.meter_two[57:48]};
            IDX_METER_THREE_LOW_WORD:        r[REG_W-1:0] = s.meter_three[15:0];
            IDX_METER_THREE_MID_WORD:        r[REG_W-1:0] = s.meter_three[31:16];
            IDX_METER_THREE_LOWER_HIGH_WORD: r[REG_W-1:0] = s.meter_three[47:32];
            IDX_METER_THREE_TOP_WORD:
                r[REG_W-1:0] = {6'h00, s.meter_three[57:48]};
            default:                         r = {1'b0, 16'h0000};
        endcase
        return r;
    endfunction : read_word

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [REG_W:0]           rd;
        logic [AXI_ADDR_W-1:0]    ra;
        logic [REG_W-1:0]         bmask;
        rd    = '0;
        ra    = '0;
        bmask = '0;
        s_nxt = s_r;

        // measurement results; software has no write path into them
        if (meter_update) begin
            s_nxt.meter_two   = third_meter_result;
            s_nxt.meter_three = fourth_meter_result;
        end

        // write address and data are caught in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_held    = 1'b1;
            s_nxt.wr_idx     = s_axi_awaddr[BYTE_SHIFT +: IDX_W];
            s_nxt.wr_aligned = (s_axi_awaddr[BYTE_SHIFT-1:0] == 2'h0) &&
                               (s_axi_awaddr[AXI_ADDR_W-1:BYTE_SHIFT+IDX_W] == '0);
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_held  = 1'b1;
            s_nxt.wr_data = s_axi_wdata[REG_W-1:0];
            s_nxt.wr_strb = s_axi_wstrb[1:0];
        end

        // commit one cycle after both halves are held
        if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            if (!s_r.wr_aligned) begin
                s_nxt.bresp = RESP_DECERR;
            end else if (s_r.wr_idx == IDX_GAIN_LOOP_FILTER_CONFIG) begin
                bmask       = {{8{s_r.wr_strb[1]}}, {8{s_r.wr_strb[0]}}} & CFG_USED_MASK;
                s_nxt.cfg   = (s_r.cfg & ~bmask) | (s_r.wr_data & bmask);
                s_nxt.bresp = RESP_OKAY;
            end else if (read_word(s_r.wr_idx, s_r)[REG_W]) begin
                s_nxt.bresp = RESP_OKAY;
            end else begin
                s_nxt.bresp = RESP_DECERR;
            end
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // read answers from registered state, one cycle after the address
        if (s_axi_arvalid && s_r.arready) begin
            ra           = s_axi_araddr;
            rd           = read_word(ra[BYTE_SHIFT +: IDX_W], s_r);
            if (ra[BYTE_SHIFT-1:0] != 2'h0 ||
                ra[AXI_ADDR_W-1:BYTE_SHIFT+IDX_W] != '0) begin
                rd = '0;
            end
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = {16'h0000, rd[REG_W-1:0]};
            s_nxt.rresp  = rd[REG_W] ? RESP_OKAY : RESP_DECERR;
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // one write and one read outstanding at most
        s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;

        s_nxt.chan = routed_sample;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r             <= '0;
            s_r.meter_two   <= METER_RESET;
            s_r.meter_three <= METER_RESET;
            s_r.cfg         <= CFG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready            = s_r.awready;
    assign s_axi_wready             = s_r.wready;
    assign s_axi_bvalid             = s_r.bvalid;
    assign s_axi_bresp              = s_r.bresp;
    assign s_axi_arready            = s_r.arready;
    assign s_axi_rvalid             = s_r.rvalid;
    assign s_axi_rdata              = s_r.rdata;
    assign s_axi_rresp              = s_r.rresp;
    assign chan_sample              = s_r.chan;
    assign highpass_enable_bit      = hp_field;
    assign signal_detect_enable_bit = sd_field;
    assign gain_bypass              = byp_field;

endmodule : power_meter_readout_agc_cfg

// ### testbench/power_meter_readout_agc_cfg_chk.sv
`timescale 1ns/100ps
module power_meter_readout_agc_cfg_chk
    import meter_agc_pkg::*;
#(
    parameter int unsigned CHANNELS = 4,
    parameter int unsigned SAMPLE_W = 16
) (
    // clock and reset
    input wire logic                         aclk,
    input wire logic                         aresetn,
    // write side
    input wire logic [AXI_ADDR_W-1:0]        s_axi_awaddr,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic [AXI_DATA_W-1:0]        s_axi_wdata,
    input wire logic [AXI_DATA_W/8-1:0]      s_axi_wstrb,
    input wire logic                         s_axi_wvalid,
    input wire logic                         s_axi_wready,
    input wire logic [1:0]                   s_axi_bresp,
    input wire logic                         s_axi_bvalid,
    // read side
    input wire logic [AXI_ADDR_W-1:0]        s_axi_araddr,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic [AXI_DATA_W-1:0]        s_axi_rdata,
    input wire logic [1:0]                   s_axi_rresp,
    input wire logic                         s_axi_rvalid,
    input wire logic                         s_axi_rready,
    // datapath
    input wire logic [CHANNELS*SAMPLE_W-1:0] raw_sample,
    input wire logic [CHANNELS*SAMPLE_W-1:0] gain_adjusted_sample,
    input wire logic [CHANNELS*SAMPLE_W-1:0] chan_sample,
    input wire logic [CHANNELS-1:0]          highpass_enable_bit,
    input wire logic [CHANNELS-1:0]          signal_detect_enable_bit,
    input wire logic [CHANNELS-1:0]          gain_bypass
);
    logic [CHANNELS*SAMPLE_W-1:0] mux_c;
    logic [11:0]                  cfg_view;
    logic [11:0]                  wdata_cfg;
    assign wdata_cfg = s_axi_wdata[15:4];
    // config word seen back in register bit order, channel i at base - i
    always_comb begin
        cfg_view = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            mux_c[i*SAMPLE_W +: SAMPLE_W] = gain_bypass[i] ? raw_sample[i*SAMPLE_W +: SAMPLE_W]
                : gain_adjusted_sample[i*SAMPLE_W +: SAMPLE_W];
            cfg_view[11-i] = highpass_enable_bit[i];
            cfg_view[7-i]  = signal_detect_enable_bit[i];
            cfg_view[3-i]  = gain_bypass[i];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    AST_RD_LAT: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");
    AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not freed after data taken");
    AST_TOP_ZERO: assert property (rd_take ##0 (s_axi_araddr == 12'h0ac || s_axi_araddr == 12'h0bc)
        |=> s_axi_rdata[15:10] == 6'h00)
        else $error("unused top bits of meter word not zero");
    AST_DECODE: assert property (rd_take ##0 (s_axi_araddr[11:8] != 4'h0)
        |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
        else $error("out of range read not refused");
    AST_WR_RESP: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response timing wrong");
    AST_CFG: assert property (wr_take ##0 (s_axi_awaddr == 12'h000 && s_axi_wstrb[1:0] == 2'h3)
        |-> ##2 cfg_view == $past(wdata_cfg, 2))
        else $error("config outputs do not follow written word");
    AST_MUX: assert property ($past(aresetn) |-> chan_sample == $past(mux_c))
        else $error("sample routing does not follow bypass");
    AST_METER_WR: assert property (wr_take ##0 (s_axi_awaddr[11:4] == 8'h0a)
        |-> ##2 s_axi_bresp == RESP_OKAY)
        else $error("meter word write not answered okay");
endmodule : power_meter_readout_agc_cfg_chk

bind power_meter_readout_agc_cfg power_meter_readout_agc_cfg_chk #(
    .CHANNELS(CHANNELS), .SAMPLE_W(SAMPLE_W)
) u_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .raw_sample, .gain_adjusted_sample, .chan_sample, .highpass_enable_bit,
    .signal_detect_enable_bit, .gain_bypass
);

// ### testbench/power_meter_readout_agc_cfg_test.sv
`timescale 1ns/100ps
module power_meter_readout_agc_cfg_test
    import meter_agc_pkg::*;
;
    typedef struct packed {logic wr; logic [11:0] a; logic [15:0] d; logic [1:0] r; logic [15:0] x;} row_t;
    logic                  aclk, aresetn, meter_update, s_axi_bready, s_axi_rready;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0]           s_axi_awaddr, s_axi_araddr;
    logic [2:0]            s_axi_awprot, s_axi_arprot;
    logic [31:0]           s_axi_wdata, s_axi_rdata, dat;
    logic [3:0]            s_axi_wstrb, highpass_enable_bit, signal_detect_enable_bit, gain_bypass;
    logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
    logic [METER_W-1:0]    third_meter_result, fourth_meter_result;
    logic [63:0]           raw_sample, gain_adjusted_sample, chan_sample;
    int                    mismatches, compares, cycles;
    localparam row_t ROWS [15] = '{
        '{1'b0, 12'h0a0, 16'h0, RESP_OKAY, 16'h7654}, '{1'b0, 12'h0a4, 16'h0, RESP_OKAY, 16'hba98},
        '{1'b0, 12'h0a8, 16'h0, RESP_OKAY, 16'hfedc}, '{1'b0, 12'h0ac, 16'h0, RESP_OKAY, 16'h03ff},
        '{1'b0, 12'h0b0, 16'h0, RESP_OKAY, 16'h8001}, '{1'b0, 12'h0b4, 16'h0, RESP_OKAY, 16'h1111},
        '{1'b0, 12'h0b8, 16'h0, RESP_OKAY, 16'h0f0f}, '{1'b0, 12'h0bc, 16'h0, RESP_OKAY, 16'h01a5},
        '{1'b1, 12'h0a4, 16'hffff, RESP_OKAY, 16'h0}, '{1'b0, 12'h0a4, 16'h0, RESP_OKAY, 16'hba98},
        '{1'b1, 12'h000, 16'ha5a5, RESP_OKAY, 16'h0}, '{1'b0, 12'h000, 16'h0, RESP_OKAY, 16'ha5a0},
        '{1'b0, 12'h100, 16'h0, RESP_DECERR, 16'h0}, '{1'b1, 12'h004, 16'h1234, RESP_DECERR, 16'h0},
        '{1'b0, 12'h004, 16'h0, RESP_DECERR, 16'h0}};
    power_meter_readout_agc_cfg u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .third_meter_result, .fourth_meter_result, .meter_update,
        .raw_sample, .gain_adjusted_sample, .chan_sample, .highpass_enable_bit,
        .signal_detect_enable_bit, .gain_bypass);
    task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
        compares++;
        if (g !== x) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= {16'h0, d}; s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
            if (!w_ok && s_axi_wready === 1'b1) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata; r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin mismatches++; $display("BAD timeout expected done seen hung"); conclude(); end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {aresetn, meter_update, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_wdata, s_axi_wstrb, third_meter_result, fourth_meter_result} = '0;
        raw_sample = 64'h4444_3333_2222_1111;
        gain_adjusted_sample = 64'hdddd_cccc_bbbb_aaaa;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        third_meter_result <= 58'h3ff_fedc_ba98_7654;
        fourth_meter_result <= 58'h1a5_0f0f_1111_8001;
        meter_update <= 1'b1;
        @(posedge aclk);
        meter_update <= 1'b0;
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].d, 4'hf, rsp);
            else begin rd(ROWS[i].a, dat, rsp); chk("rdata", ROWS[i].x, dat); end
            chk("resp", ROWS[i].r, rsp);
        end
        @(posedge aclk); #1;
        chk("highpass", 4'b0101, highpass_enable_bit);
        chk("detect", 4'b1010, signal_detect_enable_bit);
        chk("bypass", 4'b0101, gain_bypass);
        chk("sample", 64'hdddd_3333_bbbb_1111, chan_sample);
        // low byte only: bypass cleared, enables in the upper byte untouched
        wr(12'h000, 16'h0000, 4'h1, rsp);
        @(posedge aclk); #1;
        chk("highpass", 4'b0101, highpass_enable_bit);
        chk("sample", 64'hdddd_cccc_bbbb_aaaa, chan_sample);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1; #1;
        chk("highpass", 4'h0, highpass_enable_bit);
        rd(12'h000, dat, rsp); chk("config", 32'h0, dat);
        rd(12'h0bc, dat, rsp); chk("meter", 32'h0, dat);
        conclude();
    end
endmodule : power_meter_readout_agc_cfg_test
